/* shared/hwmon_regs.svh */
// register map constants for the monitor configuration / temperature irq bank
// assumes an apb slave with 32-bit data; byte address is four times the index
`ifndef HWMON_REGS_SVH
`define HWMON_REGS_SVH

// register indices as printed; byte address = index * 4
`define IDX_STATUS          8'h41
`define IDX_MASK            8'h43
`define IDX_FAN_DIV         8'h47
`define IDX_BUS_ADDR        8'h48
`define IDX_VOLT_ID4        8'h49
`define IDX_TEMP_CFG        8'h4B

// field positions
`define STATUS_TEMP_BIT     4
`define MASK_TEMP_BIT       4
`define FAN_B_LSB           6
`define TEMP_HALF_BIT       7

// reset values
`define STATUS_RST          1'b0
`define MASK_RST            8'h00
`define FAN_B_RST           2'h1
`define BUS_ADDR_UPPER_RST  5'h0B
`define TEMP_CFG_RST        7'h01

// timing: enabled cycles after reset release before the straps are taken
`define STRAP_SETTLE        2'h3

`endif

/* shared/hwmon_pkg.sv */
// types for the monitor configuration / temperature irq bank
// constants live in hwmon_regs.svh; this package holds only types
package hwmon_pkg;

    // over-temperature interrupt behaviour
    typedef enum logic [1:0] {
        IRQ_REPEAT  = 2'b00,
        IRQ_ONCE    = 2'b01,
        IRQ_COMPARE = 2'b10
    } temp_irq_mode_e;

    // apb answer phase
    typedef enum logic {
        PH_IDLE   = 1'b0,
        PH_ANSWER = 1'b1
    } apb_phase_e;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // apb answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    // measurement sequencer results
    typedef struct packed {
        logic        conv_done;
        logic [8:0]  temp_value;
        logic [7:0]  hot_limit;
        logic [7:0]  hyst_limit;
    } temp_meas_s;

    // whole state of the bank
    typedef struct packed {
        apb_phase_e  phase;
        apb_rsp_s    rsp;
        logic [1:0]  strap_s1;
        logic [1:0]  strap_s2;
        logic        volt_id_s1;
        logic        volt_id_s2;
        logic [1:0]  strap_cnt;
        logic [6:0]  bus_addr;
        logic [6:0]  volt_id4_rsvd;
        logic [6:0]  temp_cfg;
        logic [7:0]  mask;
        logic [1:0]  fan_b_prescale;
        logic [2:0]  fan_b_cnt;
        logic        fan_b_count_en;
        logic        status_temp;
        logic        armed;
        logic        alarm;
        logic        int_n;
    } mon_state_s;

endpackage : hwmon_pkg

/* rtl/monitor_config_temp_irq_regs.sv */
// monitor configuration bank: fan-2 prescaler, bus address, voltage id bit 4, temperature irq
// assumes pclk at 100 MHz, straps and voltage id pin asynchronous, sequencer on pclk
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "hwmon_regs.svh"

// Functional notes
// - fan-2 code divides speed counter by 1/2/4/8
// - bus address low bits come from straps
// - address bits 0-6 writable, bit 7 read-only
// - address resets to 001011 plus strap levels
// - voltage id bit0 reads pin, bits 1-7 writable
// - mode 00 or 11 selects repeating interrupt
// - repeat mode re-raises each conversion until below hysteresis
// - mode 01 selects one-time interrupt above hot
// - one-time rearms only after dropping below hysteresis
// - one-time status clears on read, no re-set
// - mode 10 comparator: interrupt follows over-hot level
// - temperature config resets to 01h
// - read-only bit reports temperature half degree
// - mask bit 4 blocks temperature interrupt
module monitor_config_temp_irq_regs
    import hwmon_pkg::*;
(
    input  wire logic       pclk,           // 100 MHz core clock
    input  wire logic       presetn,        // async reset, active low
    input  wire logic       pce,            // clock enable, freezes all state
    input  wire apb_req_s   apb_req,        // apb request
    output apb_rsp_s        apb_rsp,        // apb answer
    input  wire temp_meas_s meas,           // sequencer results
    input  wire logic       fan_b_tick,     // fan-2 tach pulse, pclk domain
    input  wire logic       addr_strap_low, // address strap pin, async
    input  wire logic       addr_strap_high,// address strap pin, async
    input  wire logic       core_volt_id_bit4_in, // voltage id bit 4 pin, async
    output logic            fan_b_count_en, // prescaled fan-2 count enable
    output logic            int_n           // interrupt, active low
);

    // reserved voltage id register bits reset value; arbitrary neutral value
    parameter logic [6:0] VOLT_ID4_RSVD_RST = 7'h00;

    mon_state_s     st;         // registered state
    mon_state_s     next_st;    // next state
    temp_irq_mode_e mode;       // decoded interrupt mode
    logic [7:0]     idx;        // register index from byte address
    logic           addr_ok;    // word aligned and inside the index space
    logic           hit;        // index names a register
    logic           done_edge;  // access completes at this edge
    logic           rd_done;    // read completes at this edge
    logic           wr_done;    // write completes at this edge
    logic [7:0]     rd_byte;    // selected read data
    logic           above_hot;  // whole degrees above hot limit
    logic           below_hyst; // whole degrees below hysteresis limit
    logic           set_temp;   // status set event
    logic           clr_temp;   // status read clear
    logic [2:0]     fan_b_div;  // divide ratio minus one

    // mode decode: only 01 and 10 leave the default
    always_comb begin
        case (st.temp_cfg[1:0])
            2'b01:   mode = IRQ_ONCE;
            2'b10:   mode = IRQ_COMPARE;
            default: mode = IRQ_REPEAT;
        endcase
    end

    // address decode; index is byte address over four
    always_comb begin
        idx     = apb_req.paddr[9:2];
        addr_ok = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[11:10] == 2'b00);
        hit     = addr_ok && (idx == `IDX_STATUS || idx == `IDX_MASK ||
                              idx == `IDX_FAN_DIV || idx == `IDX_BUS_ADDR ||
                              idx == `IDX_VOLT_ID4 || idx == `IDX_TEMP_CFG);
    end

    // the transfer completes where the master sees pready high
    assign done_edge = apb_req.psel && apb_req.penable && st.rsp.pready;
    assign rd_done   = done_edge && !apb_req.pwrite && hit;
    assign wr_done   = done_edge && apb_req.pwrite && hit;

    // read mux; unused upper bits read zero
    always_comb begin
        case (idx)
            `IDX_STATUS:   rd_byte = 8'(st.status_temp) << `STATUS_TEMP_BIT;
            `IDX_MASK:     rd_byte = st.mask;
            `IDX_FAN_DIV:  rd_byte = 8'(st.fan_b_prescale) << `FAN_B_LSB;
            `IDX_BUS_ADDR: rd_byte = {1'b0, st.bus_addr};
            `IDX_VOLT_ID4: rd_byte = {st.volt_id4_rsvd, st.volt_id_s2};
            `IDX_TEMP_CFG: rd_byte = {meas.temp_value[0], st.temp_cfg};
            default:       rd_byte = 8'h00;
        endcase
    end

    // temperature compare in whole degrees, two's complement
    always_comb begin
        above_hot  = $signed(meas.temp_value[8:1]) > $signed(meas.hot_limit);
        below_hyst = $signed(meas.temp_value[8:1]) < $signed(meas.hyst_limit);
    end

    // divide ratio from the prescale code
    always_comb begin
        case (st.fan_b_prescale)
            2'b00:   fan_b_div = 3'h0; // divide by 1
            2'b01:   fan_b_div = 3'h1; // divide by 2
            2'b10:   fan_b_div = 3'h3; // divide by 4
            default: fan_b_div = 3'h7; // divide by 8
        endcase
    end

    // next state
    always_comb begin
        next_st  = st;
        set_temp = 1'b0;
        clr_temp = rd_done && (idx == `IDX_STATUS);

        // pin synchronisers; first stage only feeds the second
        next_st.strap_s1 = {addr_strap_high, addr_strap_low};
        next_st.strap_s2 = st.strap_s1;
        next_st.volt_id_s1 = core_volt_id_bit4_in;
        next_st.volt_id_s2 = st.volt_id_s1;

        // apb: one wait cycle, answer registered
        case (st.phase)
            PH_IDLE: begin
                next_st.rsp.pready  = 1'b0;
                next_st.rsp.pslverr = 1'b0;
                if (apb_req.psel && apb_req.penable) begin
                    next_st.phase       = PH_ANSWER;
                    next_st.rsp.pready  = 1'b1;
                    next_st.rsp.pslverr = !hit;
                    next_st.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000
                                                         : {24'h00_0000, rd_byte};
                end
            end
            PH_ANSWER: begin
                next_st.phase       = PH_IDLE;
                next_st.rsp.pready  = 1'b0;
                next_st.rsp.pslverr = 1'b0;
            end
            default: begin
                next_st.phase      = PH_IDLE;
                next_st.rsp.pready = 1'b0;
            end
        endcase

        // strap capture once the synchronisers have settled
        if (st.strap_cnt != `STRAP_SETTLE) begin
            next_st.strap_cnt = st.strap_cnt + 2'h1;
            if (st.strap_cnt == `STRAP_SETTLE - 2'h1) begin
                next_st.bus_addr[1:0] = st.strap_s2;
            end
        end

        // register writes; take effect at the completing edge only
        if (wr_done) begin
            case (idx)
                `IDX_MASK:     next_st.mask = apb_req.pwdata[7:0];
                `IDX_FAN_DIV:  next_st.fan_b_prescale = apb_req.pwdata[7:6];
                `IDX_BUS_ADDR: next_st.bus_addr = apb_req.pwdata[6:0];
                `IDX_VOLT_ID4: next_st.volt_id4_rsvd = apb_req.pwdata[7:1];
                `IDX_TEMP_CFG: next_st.temp_cfg = apb_req.pwdata[6:0];
                default:       next_st.mask = st.mask;
            endcase
        end

        // fan-2 prescaler: one enable every ratio ticks
        next_st.fan_b_count_en = 1'b0;
        if (fan_b_tick) begin
            if (st.fan_b_cnt >= fan_b_div) begin
                next_st.fan_b_cnt      = 3'h0;
                next_st.fan_b_count_en = 1'b1;
            end else begin
                next_st.fan_b_cnt = st.fan_b_cnt + 3'h1;
            end
        end

        // temperature evaluated once per finished conversion
        if (meas.conv_done) begin
            case (mode)
                IRQ_ONCE: begin
                    if (st.armed && above_hot) begin
                        set_temp      = 1'b1;
                        next_st.armed = 1'b0;
                    end else if (!st.armed && below_hyst) begin
                        next_st.armed = 1'b1;
                    end
                end
                IRQ_COMPARE: begin
                    next_st.alarm = above_hot; // no hysteresis
                end
                default: begin
                    // repeat mode keeps alarm until below hysteresis
                    if (above_hot) begin
                        next_st.alarm = 1'b1;
                    end else if (below_hyst) begin
                        next_st.alarm = 1'b0;
                    end
                    set_temp = above_hot || (st.alarm && !below_hyst);
                end
            endcase
        end

        // status sticky outside compare mode, where it follows alarm; a set in the clearing cycle wins
        if (mode == IRQ_COMPARE) begin
            next_st.status_temp = next_st.alarm;
        end else if (set_temp) begin
            next_st.status_temp = 1'b1;
        end else if (clr_temp) begin
            next_st.status_temp = 1'b0;
        end

        // interrupt from the next status, gated by the mask
        next_st.int_n = !(next_st.status_temp && !next_st.mask[`MASK_TEMP_BIT]);
    end

    // state register; frozen while pce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                <= '0;
            st.phase          <= PH_IDLE;
            st.bus_addr       <= {`BUS_ADDR_UPPER_RST, 2'b00};
            st.volt_id4_rsvd  <= VOLT_ID4_RSVD_RST;
            st.temp_cfg       <= `TEMP_CFG_RST;
            st.mask           <= `MASK_RST;
            st.fan_b_prescale <= `FAN_B_RST;
            st.status_temp    <= `STATUS_RST;
            st.armed          <= 1'b1;
            st.int_n          <= 1'b1;
        end else if (pce) begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign apb_rsp        = st.rsp;
    assign fan_b_count_en = st.fan_b_count_en;
    assign int_n          = st.int_n;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fan_b_div_one: assert property (pce && fan_b_tick && st.fan_b_prescale == 2'b00
        |=> fan_b_count_en) else $error("divide by 1 missed a tick");
    a_fan_b_no_tick: assert property (pce && !fan_b_tick |=> !fan_b_count_en)
        else $error("fan-2 enable without tick");
    a_strap_taken: assert property (pce && st.strap_cnt == 2'h2
        |=> st.bus_addr[1:0] == $past(st.strap_s2)) else $error("strap not taken");
    a_addr_bit7_zero: assert property (apb_rsp.pready && !apb_rsp.pslverr
        && $past(idx) == `IDX_BUS_ADDR |-> apb_rsp.prdata[7] == 1'b0)
        else $error("address bit 7 not zero");
    a_addr_upper_rst: assert property (st.strap_cnt != `STRAP_SETTLE
        |-> st.bus_addr[6:2] == `BUS_ADDR_UPPER_RST) else $error("address reset wrong");
    a_volt_id_bit0: assert property (pce && apb_req.psel && apb_req.penable && !apb_req.pwrite
        && st.phase == PH_IDLE && idx == `IDX_VOLT_ID4
        |=> apb_rsp.prdata[0] == $past(st.volt_id_s2)) else $error("volt id bit 0 wrong");
    a_repeat_raise: assert property (pce && mode == IRQ_REPEAT && meas.conv_done && above_hot
        |=> st.status_temp) else $error("repeat mode did not raise");
    a_once_fire: assert property (pce && mode == IRQ_ONCE && st.armed && meas.conv_done
        && above_hot |=> st.status_temp && !st.armed) else $error("one-time missed");
    a_once_quiet: assert property (pce && mode == IRQ_ONCE && !st.armed && meas.conv_done
        && !below_hyst |=> !st.armed) else $error("one-time rearmed early");
    a_compare_level: assert property (pce && mode == IRQ_COMPARE && meas.conv_done
        |=> st.status_temp == $past(above_hot)) else $error("comparator level wrong");
    a_mask_blocks: assert property (st.mask[`MASK_TEMP_BIT] |-> int_n)
        else $error("masked interrupt asserted");
    a_int_follows: assert property (st.status_temp && !st.mask[`MASK_TEMP_BIT] |-> !int_n)
        else $error("interrupt not asserted");

    c_once_fire:  cover property (mode == IRQ_ONCE && set_temp && pce);
    c_set_clear:  cover property (set_temp && clr_temp && pce);
    c_compare_on: cover property (mode == IRQ_COMPARE && !int_n);
    c_bad_addr:   cover property (apb_rsp.pready && apb_rsp.pslverr);

endmodule : monitor_config_temp_irq_regs

/* tb/apb_host_model.sv */
// apb host model: the one master that talks to the register bank
// assumes pclk is the bank clock and that one process calls xfer at a time
`timescale 1ns/1ps

module apb_host_model
    import hwmon_pkg::*;
(
    input  wire logic     pclk,    // bus clock, rising edge
    output apb_req_s      apb_req, // request towards the bank
    input  wire apb_rsp_s apb_rsp  // answer from the bank
);
    // bus idle from time zero
    initial apb_req = '0;

    // one transfer: setup, then access held until pready is sampled high
    task automatic xfer(input  logic        wr,
                        input  logic [11:0] a,
                        input  logic [31:0] wd,
                        output logic [31:0] rd,
                        output logic        err);
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, wr, a, wd}; // setup cycle
        @(posedge pclk);
        apb_req.penable <= 1'b1; // access phase
        // the bank decides the wait, so no cycle count is assumed
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata; // taken at the pready edge only
        err = apb_rsp.pslverr;
        // released lines show the inverse so a stale value never passes
        apb_req <= '{1'b0, 1'b0, ~wr, ~a, ~wd};
    endtask : xfer
endmodule : apb_host_model

/* tb/tb_top.sv */
// top bench for the monitor configuration and temperature irq bank
// assumes the host model drives apb; sequencer, fan and pins driven here
`timescale 1ns/1ps
`include "hwmon_regs.svh"

module tb_top
    import hwmon_pkg::*;
;
    logic        pclk = 1'b0;    // 100 MHz
    logic        presetn = 1'b0; // held low at start
    apb_req_s    apb_req;        // from host model
    apb_rsp_s    apb_rsp;        // from bank
    temp_meas_s  meas = '{1'b0, 9'h000, 8'h3C, 8'h32}; // hot 60, hyst 50
    logic        fan_b_tick = 1'b0;
    logic        volt_id_in = 1'b1; // voltage id bit 4 pin
    logic        fan_b_count_en;
    logic        int_n;
    int          errors = 0;
    int          comparisons = 0;
    int          cyc = 0;        // watchdog count
    int          en_cnt = 0;     // prescaled fan pulses seen
    logic [31:0] rd;
    logic        err;

    // half period of 5 ns
    always #5 pclk = ~pclk;

    apb_host_model i_host (
        .pclk    (pclk),
        .apb_req (apb_req),
        .apb_rsp (apb_rsp)
    );

    // straps fixed at high=1 low=0 for the whole run
    monitor_config_temp_irq_regs i_dut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .pce                  (1'b1),
        .apb_req              (apb_req),
        .apb_rsp              (apb_rsp),
        .meas                 (meas),
        .fan_b_tick           (fan_b_tick),
        .addr_strap_low       (1'b0),
        .addr_strap_high      (1'b1),
        .core_volt_id_bit4_in (volt_id_in),
        .fan_b_count_en       (fan_b_count_en),
        .int_n                (int_n)
    );

    // watchdog: whole run is well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            test_done;
        end
    end

    // count prescaled fan pulses
    always @(posedge pclk) begin
        if (fan_b_count_en === 1'b1) en_cnt++;
    end

    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic fin(input string n);
        $display("test %s done", n);
    endtask : fin

    // byte address is four times the index
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction : ad

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        i_host.xfer(1'b1, ad(i), {24'h000000, d}, rd, err);
    endtask : wr

    task automatic rg(input logic [7:0] i);
        i_host.xfer(1'b0, ad(i), 32'h00000000, rd, err);
    endtask : rg

    // one conversion, then check int_n once it has settled
    task automatic step(input logic [8:0] t, input logic e);
        @(posedge pclk);
        meas.conv_done <= 1'b1;
        meas.temp_value <= t;
        @(posedge pclk);
        meas.conv_done <= 1'b0;
        @(posedge pclk);
        #1;
        chk({31'h0, int_n}, {31'h0, e});
    endtask : step

    // status read clears, then check int_n
    task automatic clrc(input logic e);
        rg(`IDX_STATUS);
        // every caller reads right after a set, so the temp bit must show
        chk(rd, 32'h00000010);
        repeat (2) @(posedge pclk);
        #1;
        chk({31'h0, int_n}, {31'h0, e});
    endtask : clrc

    task automatic t_reset;
        rg(`IDX_BUS_ADDR);
        chk(rd, 32'h0000002E);
        rg(`IDX_VOLT_ID4);
        chk(rd, 32'h00000001);
        rg(`IDX_TEMP_CFG);
        chk(rd, 32'h00000001);
        chk({31'h0, int_n}, 32'h00000001);
        fin("reset");
    endtask : t_reset

    task automatic t_regs;
        wr(`IDX_BUS_ADDR, 8'hFF);
        rg(`IDX_BUS_ADDR);
        chk(rd, 32'h0000007F);
        volt_id_in <= 1'b0;
        wr(`IDX_VOLT_ID4, 8'hFF);
        rg(`IDX_VOLT_ID4);
        chk(rd, 32'h000000FE);
        // unlisted index is refused with zero data
        rg(8'h4A);
        chk({rd[30:0], err}, 32'h00000001);
        // misaligned write onto the address word is refused and has no effect
        i_host.xfer(1'b1, 12'h122, 32'h00000000, rd, err);
        chk({31'h0, err}, 32'h00000001);
        rg(`IDX_BUS_ADDR);
        chk(rd, 32'h0000007F);
        fin("regs");
    endtask : t_regs

    task automatic t_once;
        step(9'h08C, 1'b0);
        clrc(1'b1);
        step(9'h08C, 1'b1);
        step(9'h06E, 1'b1);
        step(9'h050, 1'b1);
        step(9'h08C, 1'b0);
        clrc(1'b1);
        fin("once");
    endtask : t_once

    task automatic t_repeat;
        // both encodings of the repeating mode
        for (int m = 0; m < 4; m += 3) begin
            wr(`IDX_TEMP_CFG, 8'(m));
            step(9'h050, 1'b1);
            step(9'h06E, 1'b1);
            step(9'h08C, 1'b0);
            clrc(1'b1);
            step(9'h06E, 1'b0);
            clrc(1'b1);
            step(9'h050, 1'b1);
        end
        fin("repeat");
    endtask : t_repeat

    task automatic t_comp;
        wr(`IDX_TEMP_CFG, 8'h02);
        step(9'h08C, 1'b0);
        clrc(1'b0);
        // temperature moves without a conversion: nothing may change
        @(posedge pclk);
        meas.temp_value <= 9'h050;
        repeat (3) @(posedge pclk);
        #1;
        chk({31'h0, int_n}, 32'h00000000);
        step(9'h06E, 1'b1);
        wr(`IDX_MASK, 8'h10);
        step(9'h08C, 1'b1);
        wr(`IDX_MASK, 8'h00);
        repeat (2) @(posedge pclk);
        #1;
        chk({31'h0, int_n}, 32'h00000000);
        step(9'h051, 1'b1);
        rg(`IDX_TEMP_CFG);
        chk(rd, 32'h00000082);
        step(9'h050, 1'b1);
        rg(`IDX_TEMP_CFG);
        chk(rd, 32'h00000002);
        fin("comp");
    endtask : t_comp

    task automatic t_fan;
        // rising divisors, so a leftover count stays inside the new range
        for (int c = 0; c < 4; c++) begin
            wr(`IDX_FAN_DIV, 8'(c << 6));
            rg(`IDX_FAN_DIV);
            chk(rd, 32'(c << 6));
            en_cnt = 0;
            repeat (16) begin
                @(posedge pclk);
                fan_b_tick <= 1'b1;
                @(posedge pclk);
                fan_b_tick <= 1'b0;
            end
            repeat (3) @(posedge pclk);
            chk(32'(en_cnt), 32'(16 >> c));
        end
        fin("fan");
    endtask : t_fan

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // straps are loaded a few edges after release
        repeat (6) @(posedge pclk);
        t_reset;
        t_regs;
        t_once;
        t_repeat;
        t_comp;
        t_fan;
        test_done;
    end
endmodule : tb_top
